// File: core/smr_mode_register_file.sv
`timescale 1ns/1ps
// Contract
// - latency field selects RL/WL pairs, 0001b default, codes above 0110b reserved
// - latency register decoded at mode-register address 02h
// - drive strength field at 03h, 0010b default, listed codes only
// - temperature register at 04h reports refresh-rate code in low three bits
// - codes 000b and 111b mark low or high temperature limit exceeded
// - refresh-rate bit 2 set means device above 85 degrees
// - update flag set when refresh-rate code changed since last read
// - reading temperature register clears the update flag
// - update flag is zero after power-up
// - address 05h returns fixed 8-bit maker identification
// - address 06h returns first revision identifier
// - address 07h returns second revision identifier
// - address 08h low two bits give device type
// - density in bits 5:2, I/O width in bits 7:6
// - address 09h vendor test register has no user function
// - write to 0Ah starts init, long, short or default calibration
// - reserved calibration codes are ignored, no calibration started
module smr_mode_register_file
   import smr_pkg::*;
#(
   parameter logic [7:0] MAKER_ID     = 8'h5A, // arbitrary value
   parameter logic [7:0] REVISION_ONE = 8'h11, // arbitrary value
   parameter logic [7:0] REVISION_TWO = 8'h22, // arbitrary value
   parameter logic [1:0] DEVICE_TYPE  = 2'h0,
   parameter logic [3:0] DENSITY      = 4'h4,
   parameter logic [1:0] IO_WIDTH     = 2'h1
) (
   // clock and reset
   input  wire logic         clock_in,
   input  wire logic         rst_n_in,
   // mode register command
   input  wire smr_cmd_s     cmd_in,
   output logic [7:0]        read_data_out,
   output logic              read_valid_out,
   // temperature sensor code, asynchronous
   input  wire logic [2:0]   sensor_rate_in,
   // configuration outputs
   output smr_latency_s      latency_out,
   output logic [3:0]        drive_strength_sel_out,
   output logic              derate_out,
   output logic              temp_limit_out,
   output logic              above_85c_out,
   // calibration request, one-cycle pulses
   output logic              cal_init_out,
   output logic              cal_long_out,
   output logic              cal_short_out,
   output logic              default_impedance_restore_out
);

   // ****************************************
   // parameter checks
   // ****************************************
   // reserved geometry codes would reach the controller unchanged
   initial begin
      if (DENSITY > 4'h9)
         $error("reserved density code");
      if (DEVICE_TYPE == 2'h3)
         $error("reserved device type code");
      if (IO_WIDTH == 2'h3)
         $error("unused io width code");
   end

   // ****************************************
   // reset release
   // ****************************************
   logic [1:0] rst_sync;
   logic       rst_n;
   // release is synchronised so no flop leaves reset a cycle early
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // ****************************************
   // sensor input synchroniser
   // ****************************************
   logic [2:0] sens_s1, sens_s2, sens_s3;
   // last two copies must agree, so a code caught mid-change is skipped
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         sens_s1 <= RATE_RESET;
         sens_s2 <= RATE_RESET;
         sens_s3 <= RATE_RESET;
      end else begin
         sens_s1 <= sensor_rate_in;
         sens_s2 <= sens_s1;
         sens_s3 <= sens_s2;
      end
   end

   // ****************************************
   // register state
   // ****************************************
   logic [3:0]   latency_code, next_latency_code;
   logic [3:0]   drive_sel, next_drive_sel;
   logic [2:0]   rate_code, next_rate_code;
   logic         temp_flag, next_temp_flag;
   logic [7:0]   rdata, next_rdata;
   logic         rvalid, next_rvalid;
   smr_cal_e     cal_cmd, next_cal_cmd;
   smr_latency_s lat, next_lat;
   logic         sens_stable, rate_change, rd_temp;

   // limitations of this register file:
   //  - write-only registers read back as zero, not their contents
   //  - calibration is only requested here, its timing lives elsewhere
   //  - the test register takes no writes and reads as zero
   //  - a sensor code must settle two cycles before it is taken
   //  - writes to read-only addresses are dropped without notice

   // ****************************************
   // sensor acceptance
   // ****************************************
   // sensor update
   assign sens_stable = (sens_s2 == sens_s3);
   // reserved sensor code is never published
   assign rate_change = sens_stable && (sens_s3 != rate_code)
                        && (sens_s3 != RATE_RESERVED);
   assign rd_temp = cmd_in.read_en
                    && cmd_in.mode_reg_address == ADDR_TEMP_STATUS;

   // ****************************************
   // command decode
   // ****************************************
   // register writes and the sensor update share one next-state block
   always_comb begin
      next_latency_code = latency_code;
      next_drive_sel    = drive_sel;
      next_rate_code    = rate_code;
      next_temp_flag    = temp_flag;
      next_cal_cmd      = SMR_CAL_NONE;
      if (cmd_in.write_en) begin
         unique case (cmd_in.mode_reg_address)
            ADDR_LATENCY_CONFIG: begin
               if (cmd_in.opcode_field[3:0] != 4'h0 &&
                   cmd_in.opcode_field[3:0] <= LATENCY_MAX)
                  next_latency_code = cmd_in.opcode_field[3:0];
            end
            ADDR_DRIVE_STRENGTH: begin
               if (cmd_in.opcode_field[3:0] != 4'h0 &&
                   cmd_in.opcode_field[3:0] != 4'h5 &&
                   cmd_in.opcode_field[3:0] <= 4'h7)
                  next_drive_sel = cmd_in.opcode_field[3:0];
            end
            ADDR_IMPEDANCE_CAL: begin
               unique case (cmd_in.opcode_field)
                  CAL_AFTER_INIT:      next_cal_cmd = SMR_CAL_INIT;
                  CAL_LONG:            next_cal_cmd = SMR_CAL_LONG;
                  CAL_SHORT:           next_cal_cmd = SMR_CAL_SHORT;
                  CAL_DEFAULT_RESTORE: next_cal_cmd = SMR_CAL_RESTORE;
                  default:             next_cal_cmd = SMR_CAL_NONE;
               endcase
            end
            default: ;
         endcase
      end
      if (rd_temp)
         next_temp_flag = 1'b0;
      // change sets flag, wins over read clear
      if (rate_change) begin
         next_rate_code = sens_s3;
         next_temp_flag = 1'b1;
      end
   end

   // ****************************************
   // read data
   // ****************************************
   // the temperature read returns the pair before this cycle's update
   always_comb begin
      next_rvalid = cmd_in.read_en;
      next_rdata  = UNMAPPED_READ;
      if (cmd_in.read_en) begin
         unique case (cmd_in.mode_reg_address)
            ADDR_TEMP_STATUS: begin
               next_rdata                = {5'h00, rate_code};
               next_rdata[FLAG_BIT]      = temp_flag;
            end
            ADDR_MAKER_ID:     next_rdata = MAKER_ID;
            ADDR_REVISION_ONE: next_rdata = REVISION_ONE;
            ADDR_REVISION_TWO: next_rdata = REVISION_TWO;
            ADDR_GEOMETRY:
               next_rdata = {IO_WIDTH, DENSITY, DEVICE_TYPE};
            default:           next_rdata = UNMAPPED_READ;
         endcase
      end
   end

   // ****************************************
   // latency pair table
   // ****************************************
   // latency pair table
   always_comb begin
      next_lat = {4'h3, 4'h1};
      unique case (next_latency_code)
         4'h2:    next_lat = {4'h4, 4'h2};
         4'h3:    next_lat = {4'h5, 4'h2};
         4'h4:    next_lat = {4'h6, 4'h3};
         4'h5:    next_lat = {4'h7, 4'h4};
         4'h6:    next_lat = {4'h8, 4'h4};
         default: next_lat = {4'h3, 4'h1};
      endcase
   end

   // ****************************************
   // register update
   // ****************************************
   // flag clear at reset
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         latency_code <= LATENCY_RESET;
         drive_sel    <= DRIVE_RESET;
         rate_code    <= RATE_RESET;
         temp_flag    <= 1'b0;
         rdata        <= 8'h00;
         rvalid       <= 1'b0;
         cal_cmd      <= SMR_CAL_NONE;
         lat          <= {4'h3, 4'h1};
      end else begin
         latency_code <= next_latency_code;
         drive_sel    <= next_drive_sel;
         rate_code    <= next_rate_code;
         temp_flag    <= next_temp_flag;
         rdata        <= next_rdata;
         rvalid       <= next_rvalid;
         cal_cmd      <= next_cal_cmd;
         lat          <= next_lat;
      end
   end

   // ****************************************
   // status flags
   // ****************************************
   logic derate_q, limit_q, hot_q;
   logic next_derate, next_limit, next_hot;

   always_comb begin
      next_derate = (next_rate_code == RATE_DERATE);
      next_limit  = (next_rate_code == RATE_LOW_LIMIT) ||
                    (next_rate_code == RATE_HIGH_LIMIT);
      next_hot    = next_rate_code[HOT_BIT];
   end

   // flags move in the same cycle as the stored code
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         derate_q <= 1'b0;
         limit_q  <= 1'b0;
         hot_q    <= 1'b0;
      end else begin
         derate_q <= next_derate;
         limit_q  <= next_limit;
         hot_q    <= next_hot;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign read_data_out                 = rdata;
   assign read_valid_out                = rvalid;

   // configuration and status
   assign latency_out                   = lat;
   assign drive_strength_sel_out        = drive_sel;
   assign derate_out                    = derate_q;
   assign temp_limit_out                = limit_q;
   assign above_85c_out                 = hot_q;

   // calibration pulses
   assign cal_init_out                  = cal_cmd[1];
   assign cal_long_out                  = cal_cmd[2];
   assign cal_short_out                 = cal_cmd[3];
   assign default_impedance_restore_out = cal_cmd[4];

endmodule // smr_mode_register_file

// File: inc/smr_pkg.sv
package smr_pkg;

   // ****************************************
   // mode register addresses
   // ****************************************
   localparam logic [7:0] ADDR_LATENCY_CONFIG  = 8'h02;
   localparam logic [7:0] ADDR_DRIVE_STRENGTH  = 8'h03;
   localparam logic [7:0] ADDR_TEMP_STATUS     = 8'h04;
   localparam logic [7:0] ADDR_MAKER_ID        = 8'h05;
   localparam logic [7:0] ADDR_REVISION_ONE    = 8'h06;
   localparam logic [7:0] ADDR_REVISION_TWO    = 8'h07;
   localparam logic [7:0] ADDR_GEOMETRY        = 8'h08;
   localparam logic [7:0] ADDR_VENDOR_TEST     = 8'h09;
   localparam logic [7:0] ADDR_IMPEDANCE_CAL   = 8'h0A;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int         FLAG_BIT             = 7;
   localparam int         HOT_BIT              = 2;
   localparam logic [3:0] LATENCY_RESET        = 4'h1;
   localparam logic [3:0] LATENCY_MAX          = 4'h6;
   localparam logic [3:0] DRIVE_RESET          = 4'h2;
   localparam logic [2:0] RATE_RESET           = 3'h3;
   localparam logic [2:0] RATE_RESERVED        = 3'h4;
   localparam logic [2:0] RATE_LOW_LIMIT       = 3'h0;
   localparam logic [2:0] RATE_HIGH_LIMIT      = 3'h7;
   localparam logic [2:0] RATE_DERATE          = 3'h6;
   localparam logic [7:0] UNMAPPED_READ        = 8'h00;

   // ****************************************
   // calibration commands
   // ****************************************
   localparam logic [7:0] CAL_AFTER_INIT       = 8'hFF;
   localparam logic [7:0] CAL_LONG             = 8'hAB;
   localparam logic [7:0] CAL_SHORT            = 8'h56;
   localparam logic [7:0] CAL_DEFAULT_RESTORE  = 8'hC3;

   typedef enum logic [4:0] {
      SMR_CAL_NONE    = 5'b00001,
      SMR_CAL_INIT    = 5'b00010,
      SMR_CAL_LONG    = 5'b00100,
      SMR_CAL_SHORT   = 5'b01000,
      SMR_CAL_RESTORE = 5'b10000
   } smr_cal_e;

   // mode register command from the controller
   typedef struct packed {
      logic       write_en;
      logic       read_en;
      logic [7:0] mode_reg_address;
      logic [7:0] opcode_field;
   } smr_cmd_s;

   // read and write latency pair in clocks
   typedef struct packed {
      logic [3:0] read_latency;
      logic [3:0] write_latency;
   } smr_latency_s;

endpackage

// File: tb/smr_asserts.sv
`timescale 1ns/1ps
module smr_asserts
   import smr_pkg::*;
#(parameter logic [7:0] MAKER_ID = 8'h5A) (
   input wire logic         clock_in,
   input wire logic         rst_n_in,
   input wire smr_cmd_s     cmd_in,
   input wire logic [7:0]   read_data_out,
   input wire logic         read_valid_out,
   input wire smr_latency_s latency_out,
   input wire logic [3:0]   drive_strength_sel_out,
   input wire logic         derate_out,
   input wire logic         temp_limit_out,
   input wire logic         above_85c_out,
   input wire logic         cal_init_out,
   input wire logic         cal_long_out,
   input wire logic         cal_short_out,
   input wire logic         default_impedance_restore_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   wire logic [7:0] op = cmd_in.opcode_field;
   wire logic [7:0] ma = cmd_in.mode_reg_address;
   wire logic       wr = cmd_in.write_en;
   wire logic       rd = cmd_in.read_en;
   wire logic [3:0] cal = {cal_init_out, cal_long_out, cal_short_out,
                           default_impedance_restore_out};
   property p_temp_read;
      rd && ma == 8'h04 |=> read_valid_out && read_data_out[6:3] == 4'h0;
   endproperty
   a_temp_read: assert property (p_temp_read) else $error("temp read");
   property p_maker;
      rd && ma == 8'h05 |=> read_data_out == MAKER_ID;
   endproperty
   a_maker: assert property (p_maker) else $error("maker code");
   property p_lat_map;
      wr && ma == 8'h02 && op[3:0] == 4'h4 |=> latency_out == 8'h63;
   endproperty
   a_lat_map: assert property (p_lat_map) else $error("latency pair");
   property p_lat_rsvd;
      wr && ma == 8'h02 && (op[3:0] == 4'h0 || op[3:0] > LATENCY_MAX)
         |=> $stable(latency_out);
   endproperty
   a_lat_rsvd: assert property (p_lat_rsvd) else $error("latency kept");
   property p_drv_rsvd;
      wr && ma == 8'h03 && (op[3:0] inside {4'h0, 4'h5} || op[3])
         |=> $stable(drive_strength_sel_out);
   endproperty
   a_drv_rsvd: assert property (p_drv_rsvd) else $error("drive kept");
   property p_cal_long;
      wr && ma == 8'h0A && op == 8'hAB |=> cal == 4'h4;
   endproperty
   a_cal_long: assert property (p_cal_long) else $error("long cal");
   property p_cal_rsvd;
      wr && ma == 8'h0A && !(op inside {8'hFF, 8'hAB, 8'h56, 8'hC3})
         |=> cal == 4'h0;
   endproperty
   a_cal_rsvd: assert property (p_cal_rsvd) else $error("cal ignored");
   property p_hot;
      derate_out |-> above_85c_out && !temp_limit_out;
   endproperty
   a_hot: assert property (p_hot) else $error("derate state");
endmodule // smr_asserts

bind smr_mode_register_file smr_asserts #(.MAKER_ID(MAKER_ID)) smr_asserts_i (
   .clock_in, .rst_n_in, .cmd_in, .read_data_out, .read_valid_out,
   .latency_out, .drive_strength_sel_out, .derate_out, .temp_limit_out,
   .above_85c_out, .cal_init_out, .cal_long_out, .cal_short_out,
   .default_impedance_restore_out);

// File: tb/smr_ctl.sv
`timescale 1ns/1ps
module smr_ctl
   import smr_pkg::*;
(
   // clock and read answer
   input  wire logic       clock_in,
   input  wire logic [7:0] read_data_in,
   input  wire logic       read_valid_in,
   // mode register command
   output smr_cmd_s        cmd_out
);
   initial cmd_out = '0;
   // idle lines flip so a stale address never looks valid
   task automatic idle();
      cmd_out = {2'b00, ~cmd_out[15:0]};
      @(posedge clock_in);
      #1;
   endtask
   task automatic mrw(input logic [7:0] a, input logic [7:0] d);
      cmd_out = {2'b10, a, d};
      @(posedge clock_in);
      #1;
   endtask
   task automatic mrr(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
      cmd_out = {2'b01, a, ~a};
      @(posedge clock_in);
      #1;
      d = read_data_in;
      v = read_valid_in;
   endtask
endmodule // smr_ctl

// File: tb/tb_smr_mode_register_file.sv
`timescale 1ns/1ps
module tb_smr_mode_register_file;
   import smr_pkg::*;
   logic         clock_in = 1'b0;
   logic         rst_n_in = 1'b0;
   logic [2:0]   sensor   = 3'h3;
   smr_cmd_s     cmd;
   smr_latency_s lat;
   logic [7:0]   rd, got;
   logic         rv, gv, der, lim, hot;
   logic [3:0]   drv, cal;
   int           n_fail = 0;
   int           samples_checked = 0;
   int           cyc = 0;
   initial forever #25 clock_in = ~clock_in;
   smr_ctl smr_ctl_i (.clock_in(clock_in), .read_data_in(rd),
      .read_valid_in(rv), .cmd_out(cmd));
   smr_mode_register_file #(.MAKER_ID(8'hA5), .REVISION_ONE(8'h3C),
      .REVISION_TWO(8'h7E), .DEVICE_TYPE(2'h2),
      .DENSITY(4'h9)) smr_mode_register_file_i (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .cmd_in(cmd),
      .read_data_out(rd), .read_valid_out(rv), .sensor_rate_in(sensor),
      .latency_out(lat), .drive_strength_sel_out(drv), .derate_out(der),
      .temp_limit_out(lim), .above_85c_out(hot), .cal_init_out(cal[3]),
      .cal_long_out(cal[2]), .cal_short_out(cal[1]),
      .default_impedance_restore_out(cal[0]));
   task automatic finish_test();
      if (n_fail == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      smr_ctl_i.mrr(a, got, gv);
      chk8({7'h00, gv}, 8'h01);
      chk8(got, e);
   endtask
   task automatic t_latency();
      logic [7:0] ex [6] = '{8'h31, 8'h42, 8'h52, 8'h63, 8'h74, 8'h84};
      logic [7:0] bad [3] = '{8'h07, 8'h00, 8'h0F};
      chk8(lat, 8'h31);
      foreach (ex[i]) begin
         // upper nibble set on purpose, it must be ignored
         smr_ctl_i.mrw(8'h02, 8'hF1 + 8'(i));
         chk8(lat, ex[i]);
      end
      foreach (bad[i]) begin
         smr_ctl_i.mrw(8'h02, bad[i]);
         chk8(lat, 8'h84);
      end
      smr_ctl_i.mrw(8'h12, 8'h02);
      chk8(lat, 8'h84);
      rd_chk(8'h02, 8'h00);
   endtask
   task automatic t_drive();
      logic [3:0] ok [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7};
      logic [3:0] bad [3] = '{4'h0, 4'h5, 4'h8};
      chk8({4'h0, drv}, 8'h02);
      foreach (ok[i]) begin
         smr_ctl_i.mrw(8'h03, {4'hA, ok[i]});
         chk8({4'h0, drv}, {4'h0, ok[i]});
      end
      foreach (bad[i]) begin
         smr_ctl_i.mrw(8'h03, {4'h0, bad[i]});
         chk8({4'h0, drv}, 8'h07);
      end
   endtask
   task automatic t_ids();
      logic [7:0] adr [7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h20};
      logic [7:0] ex [7] = '{8'hA5, 8'h3C, 8'h7E, 8'h66, 8'h00, 8'h00, 8'h00};
      foreach (adr[i])
         rd_chk(adr[i], ex[i]);
      smr_ctl_i.mrw(8'h05, 8'h00);
      rd_chk(8'h05, 8'hA5);
   endtask
   task automatic t_temp();
      logic [2:0] code [5] = '{3'h6, 3'h7, 3'h0, 3'h4, 3'h3};
      logic [2:0] st [5] = '{3'h5, 3'h3, 3'h2, 3'h2, 3'h0};
      logic [7:0] ex [5] = '{8'h86, 8'h87, 8'h80, 8'h00, 8'h83};
      rd_chk(8'h04, 8'h03);
      foreach (code[i]) begin
         sensor = code[i];
         repeat (6) smr_ctl_i.idle();
         chk8({5'h00, der, lim, hot}, {5'h00, st[i]});
         rd_chk(8'h04, ex[i]);
      end
      rd_chk(8'h04, 8'h03);
   endtask
   task automatic t_cal();
      logic [7:0] op [6] = '{8'hFF, 8'hAB, 8'h56, 8'hC3, 8'h00, 8'hAC};
      logic [3:0] ex [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0};
      foreach (op[i]) begin
         smr_ctl_i.mrw(8'h0A, op[i]);
         chk8({4'h0, cal}, {4'h0, ex[i]});
      end
      smr_ctl_i.mrw(8'h0A, 8'hAB);
      smr_ctl_i.idle();
      chk8({4'h0, cal}, 8'h00);
   endtask
   // a hang costs at most a few thousand cycles
   always @(posedge clock_in) begin
      cyc++;
      if (cyc > 3000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      repeat (2) @(posedge clock_in);
      #1 rst_n_in = 1'b1;
      repeat (6) smr_ctl_i.idle();
      t_latency();
      t_drive();
      t_ids();
      t_temp();
      t_cal();
      finish_test();
   end
endmodule // tb_smr_mode_register_file
